// ==== rtl/sensor_pkg.sv ====
// constants for the sensor supervision and degauss sequencing logic
// assumes a single 200 MHz clock and synchronous active-low reset
package sensor_pkg;
    localparam int CLK_MHZ              = 200;
    // times in nanoseconds as printed
    localparam int WIRE_PERSIST_NS      = 100000;
    localparam int OVR_SUPPRESS_NS      = 3000;
    localparam int DEG_START_NS         = 25600;
    localparam int DEG_ABORT_NS         = 25000;
    localparam int POWERUP_DELAY_NS     = 12000;
    localparam int ABORT_HOLD_NS        = 3300000;
    localparam int DEGAUSS_LEN_NS       = 110000000;
    // least times round up to cycles, the abort hold and the degauss length round down
    localparam int WIRE_PERSIST_CYC     = (WIRE_PERSIST_NS * CLK_MHZ + 999) / 1000;
    localparam int OVR_SUPPRESS_CYC     = (OVR_SUPPRESS_NS * CLK_MHZ + 999) / 1000;
    localparam int DEG_START_CYC        = (DEG_START_NS * CLK_MHZ + 999) / 1000;
    localparam int DEG_ABORT_CYC        = (DEG_ABORT_NS * CLK_MHZ + 999) / 1000;
    localparam int POWERUP_DELAY_CYC    = (POWERUP_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int ABORT_HOLD_CYC       = ABORT_HOLD_NS / 1000 * CLK_MHZ;
    localparam int DEGAUSS_LEN_CYC      = DEGAUSS_LEN_NS / 1000 * CLK_MHZ;
    localparam int CNT_W                = 25;
    // register offsets
    localparam logic [3:0] STATUS_ADDR  = 4'h0;
    localparam logic [3:0] MASK_ADDR    = 4'h1;
    localparam logic [3:0] CTRL_ADDR    = 4'h2;
    localparam logic [3:0] STATE_ADDR   = 4'h3;
    // status and mask bit positions
    localparam int EV_WIRE_BIT          = 0;
    localparam int EV_OVR_BIT           = 1;
    localparam int EV_DEG_DONE_BIT      = 2;
    localparam int EV_DEG_ABORT_BIT     = 3;
    localparam int EV_W                 = 4;
    // control bit positions
    localparam int CTRL_CHECK_BIT       = 0;
    localparam int CTRL_GAIN_BIT        = 1;
    localparam logic [EV_W-1:0] MASK_RST = 4'h0;
    localparam logic [1:0]      CTRL_RST = 2'h1;
    typedef enum logic [2:0] {
        ST_POWERUP,
        ST_IDLE,
        ST_DEGAUSS,
        ST_ABORT_HOLD
    } deg_state_t;
endpackage

// ==== rtl/level_timer.sv ====
// persistence timer: output rises once input has been high a full count
// input is synchronous; count must be at least one
`timescale 1ns/10ps
module level_timer
    import sensor_pkg::*;
#(
    parameter int COUNT = 1
)(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic level_in,
    output logic      held_out
);
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    wire              at_end = (cnt_reg == CNT_W'(COUNT));

    // restart on any drop so only continuous levels count
    assign cnt_next = !level_in ? '0 : (at_end ? cnt_reg : cnt_reg + 1'b1);
    assign held_out = at_end;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_next;
    end
endmodule

// ==== rtl/sensor_fault_degauss_request_control.sv ====
// supervision and degauss sequencing of a closed-loop current sensor
// assumes synchronous pins, 200 MHz ref_clk, reset from power-on detect
//
// Summary of operation
// R1 - wire-break check runs only while a coil drive output sits near ground.
// R2 - coil current low for the persistence time while checking pulls error low.
// R3 - with coil check disabled, wire break never asserts the error flag.
// R4 - controller disables coil check whenever an external coil driver is used.
// R5 - gain select high lowers internal loop gain by about 8 dB.
// R6 - amplifier over-voltage pulls the over-range flag low.
// R7 - over-range is suppressed 3 us so short transients never show.
// R8 - over-range flag is released as soon as the overload goes away.
// R9 - degauss starts only after request stays high 25.6 us; the power-up degauss of R12 needs no such hold.
// R10 - a degauss cycle lasts about 110 ms by counter.
// R11 - error flag is held low through the whole degauss cycle.
// R12 - request high at power-on starts degauss about 12 us later.
// R13 - request low for 25 us aborts a running degauss.
// R14 - probe excitation and both modulation outputs stay active in degauss.
// R15 - after abort, error low and coil driver off another 3.3 ms.
// R16 - both flags are open-drain, wired-OR with external pull-ups.
// R17 - error flag released only when no error source is active.
`timescale 1ns/10ps
module sensor_fault_degauss_request_control
    import sensor_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       degauss_request,
    input  wire logic       coil_check_enable,
    input  wire logic       gain_select,
    input  wire logic       coil_drive_a_low,
    input  wire logic       coil_drive_b_low,
    input  wire logic       coil_current_low,
    input  wire logic       amp_overvoltage,
    input  wire logic       probe_pwm,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic            irq,
    output logic            error_n_out,
    output logic            error_n_oe,
    output logic            over_range_n_out,
    output logic            over_range_n_oe,
    output logic            gain_reduce,
    output logic            coil_driver_enable,
    output logic            degauss_active,
    output logic            pwm_out,
    output logic            pwm_out_n
);
    deg_state_t          state_reg;
    deg_state_t          state_next;
    logic [CNT_W-1:0]    tmr_reg;
    logic [CNT_W-1:0]    tmr_next;
    logic                strap_reg;
    logic [EV_W-1:0]     status_reg;
    logic [EV_W-1:0]     status_next;
    logic [EV_W-1:0]     mask_reg;
    logic [1:0]          ctrl_reg;
    logic [7:0]          rdata_reg;
    logic [7:0]          rdata_next;
    logic                wire_fault_reg;
    logic                ovr_reg;
    logic                pwm_reg;
    logic                deg_hi_held;
    logic                deg_lo_held;
    logic                wire_held;
    logic                ovr_held;
    logic                wire_prev_reg;
    logic                ovr_prev_reg;

    // R1 test gating
    wire check_on   = coil_check_enable & ctrl_reg[CTRL_CHECK_BIT];
    wire near_gnd   = coil_drive_a_low | coil_drive_b_low;
    // R3 check disable
    wire wire_test  = check_on & near_gnd & coil_current_low;
    wire in_degauss = (state_reg == ST_DEGAUSS);
    wire in_hold    = (state_reg == ST_ABORT_HOLD);
    wire tmr_done   = (tmr_reg == '0);
    wire wr_status  = reg_wr & (reg_addr == STATUS_ADDR);
    wire wr_mask    = reg_wr & (reg_addr == MASK_ADDR);
    wire wr_ctrl    = reg_wr & (reg_addr == CTRL_ADDR);
    wire rd_status  = reg_rd & (reg_addr == STATUS_ADDR);
    wire deg_done   = in_degauss & tmr_done & !deg_lo_held;
    wire deg_abort  = in_degauss & deg_lo_held;
    wire wire_rise  = wire_held & !wire_prev_reg;
    wire ovr_rise   = ovr_held & !ovr_prev_reg;
    wire [EV_W-1:0] events = {deg_abort, deg_done, ovr_rise, wire_rise};

    // R9 start filter
    level_timer #(.COUNT(DEG_START_CYC)) u_deg_hi (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .level_in (degauss_request),
        .held_out (deg_hi_held)
    );
    // R13 abort filter
    level_timer #(.COUNT(DEG_ABORT_CYC)) u_deg_lo (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .level_in (!degauss_request & in_degauss),
        .held_out (deg_lo_held)
    );
    // R2 persistence timer
    level_timer #(.COUNT(WIRE_PERSIST_CYC)) u_wire (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .level_in (wire_test),
        .held_out (wire_held)
    );
    // R7 transient suppression
    level_timer #(.COUNT(OVR_SUPPRESS_CYC)) u_ovr (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .level_in (amp_overvoltage),
        .held_out (ovr_held)
    );

    always_comb
    begin
        state_next = state_reg;
        tmr_next   = tmr_done ? tmr_reg : tmr_reg - 1'b1;
        case (state_reg)
            // R12 power-up degauss
            ST_POWERUP:
                if (tmr_done)
                begin
                    state_next = strap_reg ? ST_DEGAUSS : ST_IDLE;
                    tmr_next   = CNT_W'(DEGAUSS_LEN_CYC - 1);
                end
            ST_IDLE:
                if (deg_hi_held)
                begin
                    state_next = ST_DEGAUSS;
                    tmr_next   = CNT_W'(DEGAUSS_LEN_CYC - 1);
                end
            // R10 cycle length
            ST_DEGAUSS:
                if (deg_lo_held)
                begin
                    state_next = ST_ABORT_HOLD;
                    tmr_next   = CNT_W'(ABORT_HOLD_CYC - 1);
                end
                else if (tmr_done)
                    state_next = ST_IDLE;
            // R15 post-abort hold
            ST_ABORT_HOLD:
                if (tmr_done)
                    state_next = ST_IDLE;
            default:
                state_next = ST_IDLE;
        endcase
    end

    // set wins over the read clear
    assign status_next = (rd_status ? '0 : status_reg) | events;
    assign rdata_next  = (reg_addr == STATUS_ADDR) ? {4'h0, status_reg} :
                         (reg_addr == MASK_ADDR)   ? {4'h0, mask_reg} :
                         (reg_addr == CTRL_ADDR)   ? {6'h00, ctrl_reg} :
                         (reg_addr == STATE_ADDR)  ? {5'h00, ovr_reg, wire_fault_reg,
                                                      in_degauss} : 8'h00;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            state_reg      <= ST_POWERUP;
            tmr_reg        <= CNT_W'(POWERUP_DELAY_CYC - 1);
            status_reg     <= '0;
            mask_reg       <= MASK_RST;
            ctrl_reg       <= CTRL_RST;
            rdata_reg      <= 8'h00;
            wire_fault_reg <= 1'b0;
            ovr_reg        <= 1'b0;
            pwm_reg        <= 1'b0;
            wire_prev_reg  <= 1'b0;
            ovr_prev_reg   <= 1'b0;
        end
        else
        begin
            state_reg      <= state_next;
            tmr_reg        <= tmr_next;
            status_reg     <= status_next;
            rdata_reg      <= reg_rd ? rdata_next : 8'h00;
            // R2 fault latch, clears when the test condition goes away
            wire_fault_reg <= wire_held;
            // R8 immediate release
            ovr_reg        <= ovr_held;
            // R14 probe modulation passes through in every state
            pwm_reg        <= probe_pwm;
            wire_prev_reg  <= wire_held;
            ovr_prev_reg   <= ovr_held;
            if (wr_mask)
                mask_reg <= reg_wdata[EV_W-1:0];
            if (wr_ctrl)
                ctrl_reg <= reg_wdata[1:0];
        end
    end

    // strap caught in every ST_POWERUP cycle, through reset and the power-up delay, not by the reset itself
    always_ff @(posedge ref_clk)
    begin
        if (state_reg == ST_POWERUP)
            strap_reg <= degauss_request;
    end

    wire error_src = wire_fault_reg | in_degauss | in_hold | (state_reg == ST_POWERUP);

    // R11 R17 error flag merges every source
    // R16 open drain: enable only when pulling low
    assign error_n_out        = 1'b0;
    assign error_n_oe         = error_src;
    // R6 over-range drive
    assign over_range_n_out   = 1'b0;
    assign over_range_n_oe    = ovr_reg;
    // R5 gain reduction
    assign gain_reduce        = gain_select | ctrl_reg[CTRL_GAIN_BIT];
    assign coil_driver_enable = !in_hold;
    assign degauss_active     = in_degauss;
    assign pwm_out            = pwm_reg;
    assign pwm_out_n          = !pwm_reg;
    assign reg_rdata          = rdata_reg;
    assign irq                = |(status_reg & mask_reg);
    // wr_status is accepted and ignored: status clears only by reading
    wire unused_ok = wr_status;

    // R11 degauss keeps flag low
    chk_degauss_error_low: assert property (@(posedge ref_clk) disable iff (!rst_n) // R11
        in_degauss |-> error_n_oe)
        else $error("error flag released during degauss");
    // R3 no wire fault when disabled
    chk_check_disable: assert property (@(posedge ref_clk) disable iff (!rst_n) // R3
        !coil_check_enable [*3] |-> !wire_fault_reg)
        else $error("wire fault with check disabled");
    // R7 suppression of short pulses
    chk_ovr_suppress: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7
        $rose(amp_overvoltage) |=> !over_range_n_oe [*8])
        else $error("over-range not suppressed");
    // R8 quick release
    chk_ovr_release: assert property (@(posedge ref_clk) disable iff (!rst_n) // R8
        !amp_overvoltage |=> ##1 !over_range_n_oe)
        else $error("over-range not released");
    // R15 hold after abort
    chk_abort_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // R15
        in_hold |-> (error_n_oe && !coil_driver_enable))
        else $error("abort hold not enforced");
    // R9 start needs a held request
    chk_start_filter: assert property (@(posedge ref_clk) disable iff (!rst_n) // R9
        (state_reg == ST_IDLE) && (state_next == ST_DEGAUSS) |-> $past(degauss_request, 8))
        else $error("degauss started on short request");
    // R13 abort only after low request
    chk_abort_filter: assert property (@(posedge ref_clk) disable iff (!rst_n) // R13
        in_degauss && (state_next == ST_ABORT_HOLD) |-> !$past(degauss_request, 8))
        else $error("degauss aborted without held low");
    // R17 error released only without sources
    chk_error_release: assert property (@(posedge ref_clk) disable iff (!rst_n) // R17
        !error_n_oe |-> (!wire_fault_reg && (state_reg == ST_IDLE)))
        else $error("error released with source active");
    // R14 complementary, skip the cycle that still shows reset
    chk_pwm_pair: assert property (@(posedge ref_clk) disable iff (!rst_n) // R14
        (pwm_out == !pwm_out_n) && (!$past(rst_n) || (pwm_out == $past(probe_pwm))))
        else $error("modulation outputs not active");
    // R1 test needs a drive near ground
    chk_wire_gate: assert property (@(posedge ref_clk) disable iff (!rst_n) // R1
        !coil_drive_a_low && !coil_drive_b_low |=> ##1 !wire_fault_reg)
        else $error("wire fault without drive near ground");
    // R2 fault only after persistent low current
    chk_wire_persist: assert property (@(posedge ref_clk) disable iff (!rst_n) // R2
        $rose(wire_fault_reg) |-> $past(wire_test, 2) && $past(wire_test, 8))
        else $error("wire fault without persistent low current");
    // R3 control bit also disables the check
    chk_ctrl_disable: assert property (@(posedge ref_clk) disable iff (!rst_n) // R3
        !ctrl_reg[CTRL_CHECK_BIT] [*3] |-> !wire_fault_reg)
        else $error("wire fault with control check off");
    // R6 held overload drives the flag
    chk_ovr_set: assert property (@(posedge ref_clk) disable iff (!rst_n) // R6
        ovr_held |=> over_range_n_oe)
        else $error("over-range not driven");
    // R9 short request never starts
    chk_short_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n) // R9
        (state_reg == ST_IDLE) && !$past(degauss_request) |-> (state_next != ST_DEGAUSS))
        else $error("degauss started after request low");
    // R10 full length loaded at start
    chk_degauss_timer: assert property (@(posedge ref_clk) disable iff (!rst_n) // R10
        (state_reg != ST_DEGAUSS) && (state_next == ST_DEGAUSS) |=>
            (tmr_reg == CNT_W'(DEGAUSS_LEN_CYC - 1)))
        else $error("degauss length not loaded");
    // R12 strap high starts degauss
    chk_strap_start: assert property (@(posedge ref_clk) disable iff (!rst_n) // R12
        (state_reg == ST_POWERUP) && tmr_done && strap_reg |=> in_degauss)
        else $error("power-up degauss missing");
    // R12 strap low skips degauss
    chk_strap_skip: assert property (@(posedge ref_clk) disable iff (!rst_n) // R12
        (state_reg == ST_POWERUP) && tmr_done && !strap_reg |=> (state_reg == ST_IDLE))
        else $error("power-up degauss without strap");
    // R13 high request blocks the abort
    chk_glitch_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n) // R13
        in_degauss && $past(degauss_request) |-> (state_next != ST_ABORT_HOLD))
        else $error("degauss aborted on glitch");
    // R15 hold length loaded on abort
    chk_hold_length: assert property (@(posedge ref_clk) disable iff (!rst_n) // R15
        $rose(in_hold) |-> (tmr_reg == CNT_W'(ABORT_HOLD_CYC - 1)))
        else $error("abort hold length not loaded");
endmodule

// ==== verification/sys_ctrl_model.sv ====
// system controller model: pull-ups on both flag lines, pin straps
// assumes open-drain flags pull low only while their enable is high
`timescale 1ns/10ps
module sys_ctrl_model
(
    input  wire logic error_n_out,
    input  wire logic error_n_oe,
    input  wire logic over_range_n_out,
    input  wire logic over_range_n_oe,
    input  wire logic ext_driver,
    output logic      coil_check_enable,
    output logic      gain_select,
    output logic      error_line,
    output logic      over_range_line,
    output logic      flag_line
);
    assign error_line        = error_n_oe ? error_n_out : 1'h1;
    assign over_range_line   = over_range_n_oe ? over_range_n_out : 1'h1;
    assign flag_line         = error_line & over_range_line;
    assign coil_check_enable = ~ext_driver;
    assign gain_select       = ext_driver;
endmodule

// ==== verification/tb_sensor_fault_degauss_request_control.sv ====
// self-checking bench for the sensor supervision block
// assumes the package, design and controller model are compiled first
`timescale 1ns/10ps
module tb_sensor_fault_degauss_request_control;
    import sensor_pkg::*;
    typedef struct packed {logic ext; logic [1:0] ctrl; logic pwm; logic gain;} row_t;
    localparam int LIMIT = 90000;
    logic       ref_clk          = 1'h0;
    logic       rst_n            = 1'h0;
    logic       degauss_request  = 1'h0;
    logic       ext_driver       = 1'h0;
    logic       coil_drive_a_low = 1'h0;
    logic       coil_drive_b_low = 1'h0;
    logic       coil_current_low = 1'h0;
    logic       amp_overvoltage  = 1'h0;
    logic       probe_pwm        = 1'h0;
    logic [3:0] reg_addr         = 4'h0;
    logic [7:0] reg_wdata        = 8'h0;
    logic       reg_wr           = 1'h0;
    logic       reg_rd           = 1'h0;
    logic [7:0] reg_rdata;
    logic       irq, error_n_out, error_n_oe, over_range_n_out, over_range_n_oe;
    logic       gain_reduce, coil_driver_enable, degauss_active, pwm_out, pwm_out_n;
    logic       coil_check_enable, gain_select, error_line, over_range_line, flag_line;
    int         err_total        = 0;
    int         checked          = 0;
    int         cycles           = 0;
    row_t       rows [5]         = '{5'h06, 5'h15, 5'h0f, 5'h19, 5'h00};

    sensor_fault_degauss_request_control DUT (.ref_clk, .rst_n, .degauss_request, .coil_check_enable,
        .gain_select, .coil_drive_a_low, .coil_drive_b_low, .coil_current_low,
        .amp_overvoltage, .probe_pwm, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .irq, .error_n_out, .error_n_oe, .over_range_n_out, .over_range_n_oe, .gain_reduce,
        .coil_driver_enable, .degauss_active, .pwm_out, .pwm_out_n);
    sys_ctrl_model ctrl (.error_n_out, .error_n_oe, .over_range_n_out, .over_range_n_oe,
        .ext_driver, .coil_check_enable, .gain_select, .error_line, .over_range_line,
        .flag_line);

    initial forever #2.5 ref_clk = ~ref_clk;

    task automatic conclude;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // hang guard, well above the planned run length
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            err_total++;
            $display("wrong value cycle limit expected 0 seen %0d", cycles);
            conclude;
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'h1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr    <= 1'h0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
        @(posedge ref_clk);
        reg_rd   <= 1'h1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd   <= 1'h0;
        #1 chk(nm, e, reg_rdata);
    endtask

    task automatic reset_with(input logic req);
        @(posedge ref_clk);
        rst_n           <= 1'h0;
        degauss_request <= req;
        cyc(16);
        #1 chk("rst error", 8'h0, 8'(error_line));
        chk("rst coil", 8'h1, 8'(coil_driver_enable));
        @(posedge ref_clk);
        rst_n <= 1'h1;
    endtask

    initial
    begin
        reset_with(1'h0);
        cyc(POWERUP_DELAY_CYC - 10);
        #1 chk("wait error", 8'h0, 8'(error_line));
        cyc(20);
        #1 chk("no strap", 8'h0, 8'(degauss_active));
        chk("ready", 8'h1, 8'(flag_line));
        rd(MASK_ADDR, 8'(MASK_RST), "mask rst");
        rd(CTRL_ADDR, 8'(CTRL_RST), "ctrl rst");
        rd(4'hf, 8'h0, "unmapped");
        wr(STATUS_ADDR, 8'hff);
        rd(STATUS_ADDR, 8'h0, "status ro");
        $display("test registers done");
        foreach (rows[i])
        begin
            wr(CTRL_ADDR, {6'h0, rows[i].ctrl});
            ext_driver <= rows[i].ext;
            probe_pwm  <= rows[i].pwm;
            cyc(1);
            #1 chk("gain", 8'(rows[i].gain), 8'(gain_reduce));
            chk("pwm", {6'h0, rows[i].pwm, ~rows[i].pwm}, {6'h0, pwm_out, pwm_out_n});
            rd(CTRL_ADDR, {6'h0, rows[i].ctrl}, "ctrl");
        end
        wr(CTRL_ADDR, 8'h1);
        ext_driver      <= 1'h0;
        amp_overvoltage <= 1'h1;
        cyc(OVR_SUPPRESS_CYC - 20);
        amp_overvoltage <= 1'h0;
        cyc(10);
        rd(STATUS_ADDR, 8'h0, "transient");
        cyc(1);
        amp_overvoltage <= 1'h1;
        cyc(OVR_SUPPRESS_CYC - 10);
        #1 chk("ovr early", 8'h1, 8'(over_range_line));
        cyc(20);
        #1 chk("ovr flag", 8'h0, 8'(over_range_line));
        chk("masked irq", 8'h0, 8'(irq));
        wr(MASK_ADDR, 8'h2);
        cyc(1);
        #1 chk("irq", 8'h1, 8'(irq));
        cyc(1);
        amp_overvoltage <= 1'h0;
        cyc(2);
        #1 chk("ovr release", 8'h1, 8'(over_range_line));
        rd(STATUS_ADDR, 8'h2, "ovr status");
        rd(STATUS_ADDR, 8'h0, "status clear");
        #1 chk("irq clear", 8'h0, 8'(irq));
        $display("test over-range done");
        cyc(1);
        coil_current_low <= 1'h1;
        cyc(5000);
        #1 chk("no drive low", 8'h1, 8'(error_line));
        cyc(1);
        coil_drive_b_low <= 1'h1;
        cyc(WIRE_PERSIST_CYC - 10);
        #1 chk("wire early", 8'h1, 8'(error_line));
        cyc(20);
        #1 chk("wire fault", 8'h0, 8'(error_line));
        chk("wired or", 8'h0, 8'(flag_line));
        cyc(1);
        ext_driver <= 1'h1;
        cyc(3);
        #1 chk("check off", 8'h1, 8'(error_line));
        cyc(WIRE_PERSIST_CYC + 20);
        #1 chk("check off held", 8'h1, 8'(error_line));
        cyc(1);
        ext_driver       <= 1'h0;
        coil_current_low <= 1'h0;
        cyc(3);
        #1 chk("wire clear", 8'h1, 8'(error_line));
        rd(STATUS_ADDR, 8'h1, "wire status");
        $display("test wire break done");
        cyc(1);
        degauss_request <= 1'h1;
        cyc(DEG_START_CYC - 20);
        degauss_request <= 1'h0;
        cyc(20);
        #1 chk("short req", 8'h0, 8'(degauss_active));
        cyc(1);
        degauss_request <= 1'h1;
        probe_pwm       <= 1'h1;
        cyc(DEG_START_CYC + 10);
        #1 chk("degauss", 8'h1, 8'(degauss_active));
        chk("deg error", 8'h0, 8'(error_line));
        chk("deg pwm", 8'h2, {6'h0, pwm_out, pwm_out_n});
        rd(STATE_ADDR, 8'h1, "state");
        cyc(1);
        degauss_request <= 1'h0;
        cyc(DEG_ABORT_CYC - 20);
        degauss_request <= 1'h1;
        #1 chk("glitch", 8'h1, 8'(degauss_active));
        cyc(10);
        degauss_request <= 1'h0;
        cyc(DEG_ABORT_CYC + 10);
        #1 chk("abort", 8'h0, 8'(degauss_active));
        chk("abort error", 8'h0, 8'(error_line));
        chk("abort coil", 8'h0, 8'(coil_driver_enable));
        rd(STATUS_ADDR, 8'h8, "abort status");
        reset_with(1'h1);
        cyc(POWERUP_DELAY_CYC - 10);
        #1 chk("strap wait", 8'h0, 8'(degauss_active));
        cyc(20);
        #1 chk("strap deg", 8'h1, 8'(degauss_active));
        chk("strap error", 8'h0, 8'(error_line));
        $display("test degauss done");
        conclude;
    end
endmodule
